// ==== include/ssw_pkg.sv ====
// constants for the supply supervisor, watchdog and chip-select gate
// Notes on behaviour
// - supply below reset level holds reset; each assertion lasts at least 200 ms
// - supply dropping below reset level again restarts the timeout from zero
// - active-high reset is always the exact complement of active-low reset
// - kick input stuck longer than 1.6 s asserts reset for 200 ms
// - watchdog clears when reset asserts or on kick edges outside reset
// - watchdog held cleared during reset, counts right after release
// - kick input floating at mid-level disables the watchdog completely
// - warning output goes low when warning comparator trips; processor treats it as NMI
// - RAM rail uses backup cell only when below reset level and backup cell
// - backup mode: warning low, reset asserted both ways, gated chip-select high
// - backup mode ignores kick input and releases it to high impedance
// - normal operation passes every chip-select transition to the gated output
// - reset with no write window open disables path, gated chip-select high
// - reset during active chip-select keeps path open up to 18 us
// - chip-select still active at window end: path off, output high
// - chip-select rising inside window closes path at once, output high
// - disabled path keeps output high even if chip-select falls again
// - path reopens only after reset release with chip-select low
package ssw_pkg;
   localparam longint unsigned CLK_FREQ_HZ     = 200_000_000;
   localparam longint unsigned CYC_PER_US      = CLK_FREQ_HZ / 1_000_000;
   localparam longint unsigned RST_TIMEOUT_MS  = 200;
   localparam longint unsigned WDOG_TIMEOUT_MS = 1600;
   localparam longint unsigned WRITE_WIN_US    = 18;
   localparam longint unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * 1000 * CYC_PER_US;
   localparam longint unsigned WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * 1000 * CYC_PER_US;
   localparam longint unsigned WRITE_WIN_CYC   = WRITE_WIN_US * CYC_PER_US;
   localparam int RST_CNT_W  = 26;
   localparam int WDOG_CNT_W = 29;
   localparam int WIN_CNT_W  = 12;
   // synchroniser lanes
   localparam int SYNC_W       = 6;
   localparam int IDX_BELOW_RST = 0;
   localparam int IDX_BELOW_WRN = 1;
   localparam int IDX_BELOW_BKP = 2;
   localparam int IDX_KICK      = 3;
   localparam int IDX_KICK_MID  = 4;
   localparam int IDX_CS_N      = 5;
   localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 6'h20;
   typedef enum logic [2:0]
   {
      CE_OFF  = 3'b001,
      CE_ON   = 3'b010,
      CE_HOLD = 3'b100
   } ssw_ce_state_e;
endpackage : ssw_pkg

// ==== include/ssw_sync_if.sv ====
// raw and synchronised input lanes shared between top and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ssw_sync_if;
   import ssw_pkg::*;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] synced;
   modport syncer (input raw, output synced);
   modport user   (output raw, input synced);
endinterface : ssw_sync_if
`default_nettype wire

// ==== src/ssw_sync.sv ====
// two-flop synchroniser bank for the comparator, kick and chip-select lanes
`timescale 1ns/1ps
`default_nettype none
module ssw_sync
   import ssw_pkg::*;
(
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   ssw_sync_if.syncer  lanes
);
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++)
      begin : g_lane
         // first stage feeds only the second stage
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
            begin
               meta_reg[g] <= SYNC_RST_VAL[g];
               sync_reg[g] <= SYNC_RST_VAL[g];
            end
            else
            begin
               meta_reg[g] <= lanes.raw[g];
               sync_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate
   assign lanes.synced = sync_reg;
endmodule : ssw_sync
`default_nettype wire

// ==== src/ssw_top.sv ====
// supply supervisor: reset timer, watchdog, backup select and chip-select gate
`timescale 1ns/1ps
`default_nettype none
module ssw_top
   import ssw_pkg::*;
#(
   parameter int unsigned RST_CYCLES  = 32'(RST_TIMEOUT_CYC),
   parameter int unsigned WDOG_CYCLES = 32'(WDOG_TIMEOUT_CYC),
   parameter int unsigned WIN_CYCLES  = 32'(WRITE_WIN_CYC)
)
(
   input  wire logic MCLK_IN,
   input  wire logic SYS_RST_IN,
   input  wire logic SUPPLY_BELOW_RESET_IN,
   input  wire logic SUPPLY_BELOW_WARN_IN,
   input  wire logic SUPPLY_BELOW_BACKUP_IN,
   input  wire logic WATCHDOG_KICK_IN,
   input  wire logic WATCHDOG_KICK_MID_IN,
   input  wire logic CHIP_SEL_N_IN,
   output var  logic RESET_N_OUT,
   output var  logic RESET_OUT,
   output var  logic SUPPLY_WARNING_N_OUT,
   output var  logic RAM_FROM_BACKUP_OUT,
   output var  logic WATCHDOG_KICK_HIZ_OUT,
   output var  logic CHIP_SEL_N_OUT
);

   ssw_sync_if lanes ();

   assign lanes.raw[IDX_BELOW_RST] = SUPPLY_BELOW_RESET_IN;
   assign lanes.raw[IDX_BELOW_WRN] = SUPPLY_BELOW_WARN_IN;
   assign lanes.raw[IDX_BELOW_BKP] = SUPPLY_BELOW_BACKUP_IN;
   assign lanes.raw[IDX_KICK]      = WATCHDOG_KICK_IN;
   assign lanes.raw[IDX_KICK_MID]  = WATCHDOG_KICK_MID_IN;
   assign lanes.raw[IDX_CS_N]      = CHIP_SEL_N_IN;

   ssw_sync u_sync
   (
      .clk_in (MCLK_IN),
      .rst_in (SYS_RST_IN),
      .lanes  (lanes)
   );

   logic below_rst;
   logic below_wrn;
   logic below_bkp;
   logic kick;
   logic kick_mid;
   logic cs_n;
   logic backup_mode;

   assign below_rst = lanes.synced[IDX_BELOW_RST];
   assign below_wrn = lanes.synced[IDX_BELOW_WRN];
   assign below_bkp = lanes.synced[IDX_BELOW_BKP];
   assign kick      = lanes.synced[IDX_KICK];
   assign kick_mid  = lanes.synced[IDX_KICK_MID];
   assign cs_n      = lanes.synced[IDX_CS_N];

   // both comparators needed, not just a low supply
   assign backup_mode = below_rst & below_bkp;

   // ---------------- reset timer ----------------
   logic                 rst_reg;
   logic                 rst_next;
   logic [RST_CNT_W-1:0] rst_cnt_reg;
   logic [RST_CNT_W-1:0] rst_cnt_next;
   logic                 wd_fire_reg;

   always_comb
   begin
      rst_next     = rst_reg;
      rst_cnt_next = rst_cnt_reg;
      if (below_rst || wd_fire_reg)
      begin
         // any new cause restarts the full timeout
         rst_next     = 1'b1;
         rst_cnt_next = '0;
      end
      else if (rst_reg)
      begin
         if (rst_cnt_reg == RST_CNT_W'(RST_CYCLES - 1))
         begin
            rst_next     = 1'b0;
            rst_cnt_next = '0;
         end
         else
         begin
            rst_cnt_next = rst_cnt_reg + RST_CNT_W'(1'b1);
         end
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         rst_reg     <= 1'b1;
         rst_cnt_reg <= '0;
      end
      else
      begin
         rst_reg     <= rst_next;
         rst_cnt_reg <= rst_cnt_next;
      end
   end

   // both pins from one next value so they can never disagree
   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         RESET_N_OUT <= 1'b0;
         RESET_OUT   <= 1'b1;
      end
      else
      begin
         RESET_N_OUT <= ~rst_next;
         RESET_OUT   <= rst_next;
      end
   end

   // ---------------- watchdog ----------------
   logic                  kick_prev_reg;
   logic                  kick_edge;
   logic                  wd_enable;
   logic [WDOG_CNT_W-1:0] wd_cnt_reg;

   assign kick_edge = kick ^ kick_prev_reg;
   // floating kick or backup mode: watchdog does nothing
   assign wd_enable = ~kick_mid & ~backup_mode;

   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         kick_prev_reg <= 1'b0;
      end
      else
      begin
         kick_prev_reg <= kick;
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         wd_cnt_reg  <= '0;
         wd_fire_reg <= 1'b0;
      end
      else if (rst_reg || !wd_enable)
      begin
         wd_cnt_reg  <= '0;
         wd_fire_reg <= 1'b0;
      end
      else if (kick_edge)
      begin
         wd_cnt_reg  <= '0;
         wd_fire_reg <= 1'b0;
      end
      else if (wd_cnt_reg == WDOG_CNT_W'(WDOG_CYCLES - 1))
      begin
         wd_cnt_reg  <= '0;
         wd_fire_reg <= 1'b1;
      end
      else
      begin
         wd_cnt_reg  <= wd_cnt_reg + WDOG_CNT_W'(1'b1);
         wd_fire_reg <= 1'b0;
      end
   end

   // ---------------- supply status pins ----------------
   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         SUPPLY_WARNING_N_OUT  <= 1'b1;
         RAM_FROM_BACKUP_OUT   <= 1'b0;
         WATCHDOG_KICK_HIZ_OUT <= 1'b0;
      end
      else
      begin
         SUPPLY_WARNING_N_OUT  <= ~(below_wrn | backup_mode);
         RAM_FROM_BACKUP_OUT   <= backup_mode;
         WATCHDOG_KICK_HIZ_OUT <= backup_mode;
      end
   end

   // ---------------- chip-select gate ----------------
   ssw_ce_state_e        ce_state_reg;
   ssw_ce_state_e        ce_state_next;
   logic [WIN_CNT_W-1:0] win_cnt_reg;
   logic                 win_last;

   assign win_last = (win_cnt_reg == WIN_CNT_W'(WIN_CYCLES - 1));

   always_comb
   begin
      ce_state_next = ce_state_reg;
      case (ce_state_reg)
         CE_OFF:
         begin
            if (!rst_reg && !cs_n)
            begin
               ce_state_next = CE_ON;
            end
         end
         CE_ON:
         begin
            if (rst_reg)
            begin
               // a write in flight gets its completion window
               ce_state_next = cs_n ? CE_OFF : CE_HOLD;
            end
         end
         CE_HOLD:
         begin
            if (cs_n || win_last || backup_mode)
            begin
               ce_state_next = CE_OFF;
            end
         end
         default:
         begin
            ce_state_next = CE_OFF;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         ce_state_reg <= CE_OFF;
      end
      else
      begin
         ce_state_reg <= ce_state_next;
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN || ce_state_reg != CE_HOLD)
      begin
         win_cnt_reg <= '0;
      end
      else if (!win_last)
      begin
         win_cnt_reg <= win_cnt_reg + WIN_CNT_W'(1'b1);
      end
   end

   // output follows the input only while the path is open
   always_ff @(posedge MCLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         CHIP_SEL_N_OUT <= 1'b1;
      end
      else if (backup_mode)
      begin
         CHIP_SEL_N_OUT <= 1'b1;
      end
      else if (ce_state_next == CE_OFF)
      begin
         CHIP_SEL_N_OUT <= 1'b1;
      end
      else
      begin
         CHIP_SEL_N_OUT <= cs_n;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   property p_low_supply_reset;
      below_rst |=> rst_reg && (rst_cnt_reg == '0);
   endproperty
   a_low_supply_reset: assert property (p_low_supply_reset)
      else $error("reset not restarted on low supply");

   property p_reset_min_time;
      $rose(rst_reg) |-> ##1 rst_reg [*8];
   endproperty
   a_reset_min_time: assert property (p_reset_min_time)
      else $error("reset released too early");

   property p_reset_complement;
      RESET_OUT != RESET_N_OUT;
   endproperty
   a_reset_complement: assert property (p_reset_complement)
      else $error("reset pins not complementary");

   property p_wd_fires_reset;
      wd_fire_reg |=> rst_reg ##1 !RESET_N_OUT;
   endproperty
   a_wd_fires_reset: assert property (p_wd_fires_reset)
      else $error("watchdog expiry did not assert reset");

   property p_kick_clears;
      (kick_edge && !rst_reg) |=> (wd_cnt_reg == '0) && !wd_fire_reg;
   endproperty
   a_kick_clears: assert property (p_kick_clears)
      else $error("kick edge did not clear watchdog");

   property p_wd_held_in_reset;
      rst_reg |=> (wd_cnt_reg == '0);
   endproperty
   a_wd_held_in_reset: assert property (p_wd_held_in_reset)
      else $error("watchdog counted during reset");

   property p_mid_kick_silent;
      kick_mid |=> !wd_fire_reg;
   endproperty
   a_mid_kick_silent: assert property (p_mid_kick_silent)
      else $error("watchdog fired with kick floating");

   property p_warning;
      below_wrn |=> !SUPPLY_WARNING_N_OUT;
   endproperty
   a_warning: assert property (p_warning)
      else $error("warning not driven low");

   property p_backup_pins;
      backup_mode |=> RAM_FROM_BACKUP_OUT && !RESET_N_OUT && CHIP_SEL_N_OUT
                      && WATCHDOG_KICK_HIZ_OUT;
   endproperty
   a_backup_pins: assert property (p_backup_pins)
      else $error("backup mode pin state wrong");

   property p_pass_through;
      (ce_state_reg == CE_ON && !rst_reg && !backup_mode) |=> CHIP_SEL_N_OUT == $past(cs_n);
   endproperty
   a_pass_through: assert property (p_pass_through)
      else $error("chip-select not passed through");

   property p_window_opens;
      (ce_state_reg == CE_ON && rst_reg && !cs_n) |=> ce_state_reg == CE_HOLD;
   endproperty
   a_window_opens: assert property (p_window_opens)
      else $error("write window not opened");

   property p_window_ends;
      (ce_state_reg == CE_HOLD && (cs_n || win_last)) |-> ##1 CHIP_SEL_N_OUT ##1 ce_state_reg == CE_OFF;
   endproperty
   a_window_ends: assert property (p_window_ends)
      else $error("write window did not close");

   property p_off_stays_high;
      (ce_state_reg == CE_OFF && rst_reg) |=> CHIP_SEL_N_OUT;
   endproperty
   a_off_stays_high: assert property (p_off_stays_high)
      else $error("gated chip-select low while path disabled");

endmodule : ssw_top
`default_nettype wire

// ==== testbench/ssw_cpu_model.sv ====
// processor-side model: watchdog kicker and warning interrupt latch
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model
(
   input  wire logic       clk_in,
   input  wire logic       warn_n_in,
   input  wire logic       kick_en_in,
   input  wire logic [7:0] kick_gap_in,
   output var  logic       kick_out,
   output var  logic       nmi_seen_out
);
   logic [7:0] gap_reg;

   initial
   begin
      kick_out = 1'b0;
      nmi_seen_out = 1'b0;
      gap_reg = 8'h00;
   end

   // driven off the falling edge, like the bench
   always @(negedge clk_in)
   begin
      gap_reg <= (kick_en_in && gap_reg < kick_gap_in) ? gap_reg + 8'h01 : 8'h00;
      if (kick_en_in && gap_reg == kick_gap_in)
         kick_out <= ~kick_out;
      if (!warn_n_in)
         nmi_seen_out <= 1'b1;
   end
endmodule : ssw_cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the supply supervisor top
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
$display("wrong value at %0t ns: got %h want %h", $time, (got), (exp)); end end
module tb_top;
   localparam int unsigned RST  = 64;
   localparam int unsigned WDOG = 200;
   localparam int unsigned WIN  = 16;
   localparam logic [5:0]  M_RC = 6'h31;
   logic        clk;
   logic        rst;
   logic        b_rst;
   logic        b_wrn;
   logic        b_bkp;
   logic        mid;
   logic        cs_n;
   logic        kick;
   logic        kick_en;
   logic        nmi;
   logic        rst_n;
   logic        rst_h;
   logic        warn_n;
   logic        bkp;
   logic        hiz;
   logic        cs_out;
   logic [11:0] note;
   logic [11:0] exp_q[$];
   event        chk_ev;
   int          err_count;
   int          comparisons;
   int          n;
   wire  [5:0]  outs = {rst_n, rst_h, warn_n, bkp, hiz, cs_out};

   ssw_top #(
      .RST_CYCLES  (RST),
      .WDOG_CYCLES (WDOG),
      .WIN_CYCLES  (WIN)
   ) DUT (
      .MCLK_IN                (clk),
      .SYS_RST_IN             (rst),
      .SUPPLY_BELOW_RESET_IN  (b_rst),
      .SUPPLY_BELOW_WARN_IN   (b_wrn),
      .SUPPLY_BELOW_BACKUP_IN (b_bkp),
      .WATCHDOG_KICK_IN       (kick),
      .WATCHDOG_KICK_MID_IN   (mid),
      .CHIP_SEL_N_IN          (cs_n),
      .RESET_N_OUT            (rst_n),
      .RESET_OUT              (rst_h),
      .SUPPLY_WARNING_N_OUT   (warn_n),
      .RAM_FROM_BACKUP_OUT    (bkp),
      .WATCHDOG_KICK_HIZ_OUT  (hiz),
      .CHIP_SEL_N_OUT         (cs_out)
   );

   ssw_cpu_model u_cpu (
      .clk_in       (clk),
      .warn_n_in    (warn_n),
      .kick_en_in   (kick_en),
      .kick_gap_in  (8'h64),
      .kick_out     (kick),
      .nmi_seen_out (nmi)
   );

   always #2.5 clk = ~clk;

   task automatic report_and_stop;
      $display("comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   // note the expected masked outputs; the monitor compares them
   task automatic expect_out(input logic [5:0] m, input logic [5:0] v);
      exp_q.push_back({m, v & m});
      -> chk_ev;
   endtask : expect_out

   // bounded wait for the reset output to reach a level
   task automatic wait_rst(input logic lvl, output int k);
      k = 0;
      while (rst_n !== lvl && k < 1000)
      begin
         @(negedge clk);
         k++;
      end
   endtask : wait_rst

   // drain every note: two notes in one time step raise only one wake-up
   always @(chk_ev)
   begin
      while (exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         `CHK(outs & note[11:6], note[5:0])
      end
   end

   always @(negedge clk)
   begin
      if (!rst)
         `CHK(rst_h, ~rst_n)
   end

   initial
   begin
      #100000;
      err_count++;
      report_and_stop();
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      b_rst = 1'b0;
      b_wrn = 1'b0;
      b_bkp = 1'b0;
      mid = 1'b0;
      cs_n = 1'b1;
      kick_en = 1'b1;
      err_count = 0;
      comparisons = 0;
      void'($urandom(57723));
      cyc(8);
      expect_out(6'h3F, 6'h19);
      rst = 1'b0;
      cs_n = 1'b0;
      cyc(RST - 8);
      expect_out(M_RC, 6'h11);
      wait_rst(1'b1, n);
      `CHK(n inside {[1:14]}, 1'b1)
      cyc(4);
      expect_out(M_RC, 6'h20);
      repeat (12)
      begin
         cs_n = 1'($urandom);
         cyc(4);
         expect_out(6'h01, {5'h00, cs_n});
      end
      // reset with no write in progress, then a restarted timeout
      cs_n = 1'b1;
      b_rst = 1'b1;
      cyc(4);
      expect_out(M_RC, 6'h11);
      cs_n = 1'b0;
      cyc(6);
      expect_out(6'h01, 6'h01);
      b_rst = 1'b0;
      cyc(40);
      b_rst = 1'b1;
      cyc(3);
      b_rst = 1'b0;
      wait_rst(1'b1, n);
      `CHK(n inside {[RST:RST + 6]}, 1'b1)
      cyc(4);
      expect_out(6'h01, 6'h00);
      // write finished inside the window
      b_rst = 1'b1;
      cyc(4);
      expect_out(M_RC, 6'h10);
      cs_n = 1'b1;
      cyc(4);
      expect_out(6'h01, 6'h01);
      cs_n = 1'b0;
      cyc(4);
      expect_out(6'h01, 6'h01);
      b_rst = 1'b0;
      wait_rst(1'b1, n);
      cyc(4);
      expect_out(6'h01, 6'h00);
      // write still open when the window runs out
      b_rst = 1'b1;
      cyc(4);
      expect_out(6'h01, 6'h00);
      cyc(WIN - 4);
      expect_out(6'h01, 6'h00);
      cyc(8);
      expect_out(6'h01, 6'h01);
      b_rst = 1'b0;
      wait_rst(1'b1, n);
      b_wrn = 1'b1;
      cyc(4);
      expect_out(6'h08, 6'h00);
      `CHK(nmi, 1'b1)
      b_wrn = 1'b0;
      cyc(4);
      expect_out(6'h08, 6'h08);
      // backup cell alone must not switch the rail
      b_bkp = 1'b1;
      cyc(4);
      expect_out(6'h06, 6'h00);
      b_rst = 1'b1;
      b_wrn = 1'b1;
      cyc(4);
      expect_out(6'h3F, 6'h17);
      expect_out(6'h02, 6'h02);
      b_bkp = 1'b0;
      cyc(4);
      expect_out(6'h36, 6'h10);
      b_rst = 1'b0;
      b_wrn = 1'b0;
      wait_rst(1'b1, n);
      repeat (16)
      begin
         cyc(50);
         expect_out(6'h30, 6'h20);
      end
      kick_en = 1'b0;
      wait_rst(1'b0, n);
      `CHK(n inside {[WDOG - 102:WDOG + 8]}, 1'b1)
      wait_rst(1'b1, n);
      `CHK(n inside {[RST:RST + 6]}, 1'b1)
      wait_rst(1'b0, n);
      `CHK(n inside {[WDOG:WDOG + 6]}, 1'b1)
      wait_rst(1'b1, n);
      // floating kick pin: no watchdog reset however long
      mid = 1'b1;
      repeat (8)
      begin
         cyc(50);
         expect_out(6'h30, 6'h20);
      end
      mid = 1'b0;
      kick_en = 1'b1;
      cyc(2);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
